// ==== arp_seq.sv ====
// Arpeggio note sequencer with an AXI4-Lite register slave.
//
// Functional notes
// - Enable toggled by panel key, LED shows it
// - Latch keeps playing after release, else stop
// - Up pattern plays low to high
// - Down pattern plays high to low
// - Alt1 alternates, ends sounded once
// - Alt2 alternates, ends sounded twice
// - Random pattern picks any held note
// - Trigger pattern retriggers whole chord, range ignored
// - Excess keys: lowest notes up to voice count
// - Range spans one to four octaves upward
// - Tempo 20 to 300, proportional step speed
// - External clock overrides internal tempo
// - Tempo also drives modulation sequence speed
// - Gate 0 to 100 percent of step
// - Dual modes route to timbre one, two, both
// - Timbre driven only on global channel
// - Key sync restarts pattern on key
// - Step resolution quarter down to sixteenth triplet
// - Swing shifts even notes by plus/minus 100 percent
// - External timing clock replaces internal tempo control
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "arp_seq_consts.svh"
module arp_seq #(
  parameter int MAX_VOICES = 8  // Most notes used at once.
) (
  input  wire logic              aclk,          // System clock, 100 MHz.
  input  wire logic              aresetn,       // Synchronous reset, active low.
  input  wire logic              s_axi_awvalid, // Write address valid.
  output logic                   s_axi_awready, // Write address ready.
  input  wire logic [7:0]        s_axi_awaddr,  // Write byte address.
  input  wire logic              s_axi_wvalid,  // Write data valid.
  output logic                   s_axi_wready,  // Write data ready.
  input  wire logic [31:0]       s_axi_wdata,   // Write data.
  input  wire logic [3:0]        s_axi_wstrb,   // Write byte enables.
  output logic                   s_axi_bvalid,  // Write response valid.
  input  wire logic              s_axi_bready,  // Write response ready.
  output logic [1:0]             s_axi_bresp,   // Write response code.
  input  wire logic              s_axi_arvalid, // Read address valid.
  output logic                   s_axi_arready, // Read address ready.
  input  wire logic [7:0]        s_axi_araddr,  // Read byte address.
  output logic                   s_axi_rvalid,  // Read data valid.
  input  wire logic              s_axi_rready,  // Read data ready.
  output logic [31:0]            s_axi_rdata,   // Read data.
  output logic [1:0]             s_axi_rresp,   // Read response code.
  input  wire arp_pkg::arp_key_t key_ev,        // Keyboard note on and off.
  input  wire logic              arp_key,       // Panel enable key pulse.
  input  wire logic              latch_key,     // Panel latch key pulse.
  input  wire logic              ext_tick,      // External timing clock pulse.
  output arp_pkg::arp_ev_t       note_ev,       // Note events to the voices.
  output logic                   arp_led,       // Enable key indicator.
  output logic                   latch_led,     // Latch key indicator.
  output logic [8:0]             seq_tempo      // Tempo for modulation sequences.
);
  import arp_pkg::*;

  // One step is FULL accumulator units; a pair of steps spans two of them.
  localparam logic [35:0] FULL     = `ARP_WHOLE_BEATS * `ARP_BEAT_SEC * `ARP_CLK_HZ;
  localparam logic [35:0] TWO_FULL = FULL + FULL;
  localparam logic [35:0] EXT_UNIT = FULL / `ARP_EXT_PPW;
  localparam logic [35:0] PCT_UNIT = FULL / `ARP_PCT_DIV;
  localparam logic [35:0] SW_UNIT  = FULL / `ARP_SWING_DIV;
  localparam logic [7:0]  VOICES   = 8'(MAX_VOICES);

  arp_st_t      st_q;      // Whole state of the block.
  arp_st_t      st_d;      // Next state.
  logic [127:0] use_set;   // Notes taken part in the pattern.
  logic [7:0]   cnt;       // Number of notes in use.
  logic [1:0]   rng;       // Octave span minus one.
  arp_pat_t     pat;       // Selected pattern.
  logic [35:0]  inc;       // Accumulator advance this cycle.
  logic [36:0]  acc_sum;   // Accumulator plus advance.
  logic [36:0]  mid;       // Position of the swung second step.
  logic         fire_a;    // Grid tick of the first step of a pair.
  logic         fire_b;    // Tick of the second, swung step.
  logic         playing;   // Enabled and notes to play.
  logic         at_top;    // Position is the highest of the span.
  logic         at_bot;    // Position is the lowest of the span.
  logic [6:0]   cur_idx;   // Position index clipped to the set.
  logic [8:0]   pos;       // Packed index and octave for stepping.
  logic [6:0]   base;      // Note picked before transposition.
  logic [7:0]   tnote;     // Transposed note.
  logic         do_emit;   // A note goes out this cycle.

  // Counts the set bits of a note map.
  function automatic logic [7:0] count_bits(input logic [127:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 128; i++) c = c + 8'(v[i]);
    return c;
  endfunction : count_bits

  // Keeps only the lowest n set bits of a note map.
  function automatic logic [127:0] limit_set(input logic [127:0] v, input logic [7:0] n);
    logic [127:0] r;
    logic [7:0]   c;
    r = '0;
    c = 8'h00;
    for (int i = 0; i < 128; i++)
    begin
      if (v[i] && c < n)
      begin
        r[i] = 1'b1;
        c = c + 8'h01;
      end
    end
    return r;
  endfunction : limit_set

  // Finds the note number of the k-th lowest set bit.
  function automatic logic [6:0] nth_bit(input logic [127:0] v, input logic [6:0] k);
    logic [6:0] r;
    logic [7:0] c;
    r = 7'h00;
    c = 8'h00;
    for (int i = 0; i < 128; i++)
    begin
      if (v[i])
      begin
        if (c == {1'b0, k}) r = 7'(i);
        c = c + 8'h01;
      end
    end
    return r;
  endfunction : nth_bit

  // Merges written bytes into a register word.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    return r;
  endfunction : merge

  // Steps per whole note for each resolution code.
  // resolution to steps
  function automatic logic [5:0] res_den(input logic [2:0] c);
    unique case (c)
      3'h0:    return 6'h04;
      3'h1:    return 6'h06;
      3'h2:    return 6'h08;
      3'h3:    return 6'h0C;
      3'h4:    return 6'h10;
      default: return 6'h18;
    endcase
  endfunction : res_den

  // Moves one position up or down through notes and octaves, wrapping round.
  function automatic logic [8:0] step(input logic [6:0] i, input logic [1:0] o,
                                      input logic [7:0] n, input logic [1:0] r,
                                      input logic up);
    logic [8:0] p;
    p = {i, o};
    if (up)
    begin
      if ({1'b0, i} + 8'h01 < n) p = {i + 7'h01, o};
      else p = {7'h00, (o >= r) ? 2'h0 : o + 2'h1};
    end
    else
    begin
      if (i != 7'h00) p = {i - 7'h01, o};
      else p = {7'(n - 8'h01), (o == 2'h0) ? r : o - 2'h1};
    end
    return p;
  endfunction : step

  // Decodes settings, picks the next note and serves the register bus.
  always_comb
  begin
    st_d    = st_q;
    use_set = limit_set(st_q.play, VOICES);
    cnt     = count_bits(use_set);
    pat     = arp_pat_t'(st_q.ctrl[`ARP_F_PAT]);
    rng     = (pat == ARP_TRIG) ? 2'h0 : st_q.ctrl[`ARP_F_RANGE];
    playing = st_q.en && (cnt != 8'h00);
    if (st_q.ctrl[`ARP_B_EXT])
      inc = ext_tick ? EXT_UNIT * 36'(res_den(st_q.ctrl[`ARP_F_RES])) : 36'h0;
    else
      inc = 36'(st_q.tmp[`ARP_F_TEMPO]) * 36'(res_den(st_q.ctrl[`ARP_F_RES]));
    acc_sum = {1'b0, st_q.acc} + {1'b0, inc};
    fire_a  = acc_sum >= {1'b0, TWO_FULL};
    mid     = 37'($signed({1'b0, FULL}) +
                  $signed(st_q.tmp[`ARP_F_SWING]) * $signed({1'b0, SW_UNIT}));
    fire_b  = ({1'b0, st_q.acc} < mid) && (acc_sum >= mid) && !fire_a;
    st_d.acc  = fire_a ? 36'(acc_sum - {1'b0, TWO_FULL}) : acc_sum[35:0];
    st_d.lfsr = {st_q.lfsr[14:0], ^(st_q.lfsr & `ARP_LFSR_TAPS)};
    cur_idx = ({1'b0, st_q.idx} >= cnt) ? 7'(cnt - 8'h01) : st_q.idx;
    at_top  = ({1'b0, cur_idx} + 8'h01 >= cnt) && (st_q.oct >= rng);
    at_bot  = (cur_idx == 7'h00) && (st_q.oct == 2'h0);
    pos     = {cur_idx, st_q.oct};
    do_emit = 1'b0;
    st_d.ev.trig = 1'b0;
    if (st_q.restart)
    begin
      st_d.acc = 36'h0;
      st_d.dn  = (pat == ARP_DOWN);
      pos      = (pat == ARP_DOWN) ? {7'(cnt - 8'h01), rng} : 9'h000;
      do_emit  = playing;
    end
    else if (fire_a || fire_b)
    begin
      do_emit = playing;
      unique case (pat)
        ARP_UP:   pos = step(cur_idx, st_q.oct, cnt, rng, 1'b1);
        ARP_DOWN: pos = step(cur_idx, st_q.oct, cnt, rng, 1'b0);
        ARP_RAND: pos = {7'(st_q.lfsr[7:0] % cnt), 2'(st_q.lfsr[9:8] % ({1'b0, rng} + 3'h1))};
        ARP_TRIG: pos = 9'h000;
        default:
        begin
          if (!st_q.dn && at_top && !at_bot)
          begin
            st_d.dn = 1'b1;
            if (pat == ARP_ALT1) pos = step(cur_idx, st_q.oct, cnt, rng, 1'b0);
          end
          else if (st_q.dn && at_bot && !at_top)
          begin
            st_d.dn = 1'b0;
            if (pat == ARP_ALT1) pos = step(cur_idx, st_q.oct, cnt, rng, 1'b1);
          end
          else if (!at_top || !at_bot)
            pos = step(cur_idx, st_q.oct, cnt, rng, !st_q.dn);
        end
      endcase
    end
    st_d.idx = pos[8:2];
    st_d.oct = pos[1:0];
    base  = nth_bit(use_set, pos[8:2]);
    tnote = {1'b0, base} + `ARP_OCT_SEMIS * {6'h00, pos[1:0]};
    if (do_emit)
    begin
      st_d.ev.trig  = 1'b1;
      st_d.ev.gate  = 1'b1;
      st_d.ev.chord = (pat == ARP_TRIG);
      st_d.ev.mask  = (pat == ARP_TRIG) ? use_set : '0;
      st_d.ev.note  = (tnote > `ARP_NOTE_TOP) ? base : tnote[6:0];
      st_d.ev.to_t1 = (!st_q.ctrl[`ARP_B_DUAL] || st_q.ctrl[`ARP_F_TSEL] != 2'h2) &&
                      (st_q.chan[`ARP_F_T1CH] == st_q.chan[`ARP_F_GCH]);
      st_d.ev.to_t2 = st_q.ctrl[`ARP_B_DUAL] && (st_q.ctrl[`ARP_F_TSEL] != 2'h1) &&
                      (st_q.chan[`ARP_F_T2CH] == st_q.chan[`ARP_F_GCH]);
      st_d.gate_rem = 36'(st_q.tmp[`ARP_F_GATE]) * PCT_UNIT;
      st_d.last_v    = (pat == ARP_UP) && !st_q.restart && (rng == 2'h0);
      st_d.last_note = st_d.ev.note;
    end
    else if (!playing)
    begin
      st_d.ev.gate = 1'b0;
    end
    else if (st_q.ev.gate && st_q.tmp[`ARP_F_GATE] != `ARP_GATE_MAX)
    begin
      // Gate falls once its share of the step has elapsed.
      if (st_q.gate_rem <= inc)
      begin
        st_d.ev.gate  = 1'b0;
        st_d.gate_rem = 36'h0;
      end
      else st_d.gate_rem = st_q.gate_rem - inc;
    end
    if (arp_key) st_d.en = !st_q.en;
    if (latch_key) st_d.latch = !st_q.latch;
    st_d.restart = (key_ev.on && (st_q.ctrl[`ARP_B_KSYNC] || st_q.held == '0)) ||
                   (arp_key && !st_q.en);
    if (key_ev.off) st_d.held[key_ev.note] = 1'b0;
    if (key_ev.on) st_d.held[key_ev.note] = 1'b1;
    if (key_ev.on || key_ev.off) st_d.last_v = 1'b0;
    if (!st_q.latch) st_d.play = st_d.held;
    else if (key_ev.on)
    begin
      if (st_q.held == '0) st_d.play = '0;
      st_d.play[key_ev.note] = 1'b1;
    end
    // Write channels are taken independently, in the same cycle when both are valid, and answered once both are in.
    if (st_q.bvalid && s_axi_bready) st_d.bvalid = 1'b0;
    if (s_axi_awvalid && !st_q.aw_v)
    begin
      st_d.aw_v    = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_v)
    begin
      st_d.w_v    = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.aw_v && st_q.w_v && !st_q.bvalid)
    begin
      st_d.aw_v   = 1'b0;
      st_d.w_v    = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = `ARP_RESP_OKAY;
      unique case (st_q.aw_addr)
        `ARP_REG_CTRL: st_d.ctrl = merge(st_q.ctrl, st_q.w_data, st_q.w_strb);
        `ARP_REG_CHAN: st_d.chan = merge(st_q.chan, st_q.w_data, st_q.w_strb);
        `ARP_REG_STAT: st_d.bresp = `ARP_RESP_OKAY;
        `ARP_REG_TEMPO:
        begin
          st_d.tmp = merge(st_q.tmp, st_q.w_data, st_q.w_strb);
          if (st_d.tmp[`ARP_F_TEMPO] < `ARP_TEMPO_MIN) st_d.tmp[`ARP_F_TEMPO] = `ARP_TEMPO_MIN;
          if (st_d.tmp[`ARP_F_TEMPO] > `ARP_TEMPO_MAX) st_d.tmp[`ARP_F_TEMPO] = `ARP_TEMPO_MAX;
          if (st_d.tmp[`ARP_F_GATE] > `ARP_GATE_MAX) st_d.tmp[`ARP_F_GATE] = `ARP_GATE_MAX;
          if ($signed(st_d.tmp[`ARP_F_SWING]) > `ARP_SWING_MAX)
            st_d.tmp[`ARP_F_SWING] = `ARP_SWING_MAX;
          if ($signed(st_d.tmp[`ARP_F_SWING]) < -`ARP_SWING_MAX)
            st_d.tmp[`ARP_F_SWING] = -`ARP_SWING_MAX;
        end
        default: st_d.bresp = `ARP_RESP_SLVERR;
      endcase
    end
    // Reads answer one cycle after the address is taken.
    if (st_q.rvalid && s_axi_rready) st_d.rvalid = 1'b0;
    if (s_axi_arvalid && !st_q.rvalid)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = `ARP_RESP_OKAY;
      unique case (s_axi_araddr)
        `ARP_REG_CTRL:  st_d.rdata = st_q.ctrl;
        `ARP_REG_TEMPO: st_d.rdata = st_q.tmp;
        `ARP_REG_CHAN:  st_d.rdata = st_q.chan;
        `ARP_REG_STAT:  st_d.rdata = {15'h0000, playing, cnt, 6'h00, st_q.latch, st_q.en};
        default:
        begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = `ARP_RESP_SLVERR;
        end
      endcase
    end
  end

  // Registers the whole state; reset loads constants only.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q      <= '0;
      st_q.ctrl <= `ARP_CTRL_RST;
      st_q.tmp  <= `ARP_TEMPO_RST;
      st_q.chan <= `ARP_CHAN_RST;
      st_q.lfsr <= `ARP_LFSR_SEED;
    end
    else st_q <= st_d;
  end

  // Handshake readies are combinational; all data comes from flip-flops.
  assign s_axi_awready = !st_q.aw_v;
  assign s_axi_wready  = !st_q.w_v;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign note_ev       = st_q.ev;
  assign arp_led       = st_q.en;
  assign latch_led     = st_q.latch;
  assign seq_tempo     = st_q.tmp[`ARP_F_TEMPO];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sync_key;
    key_ev.on && st_q.ctrl[`ARP_B_KSYNC] && st_q.en && !arp_key;
  endsequence
  sequence s_restart_out;
    ##1 st_q.restart ##1 note_ev.trig;
  endsequence

  property p_led_toggle;
    arp_key |=> arp_led != $past(arp_led);
  endproperty
  a_led_toggle: assert property (p_led_toggle) else $error("enable led not toggled");
  property p_stop_empty;
    (st_q.play == '0) |=> !note_ev.trig && !note_ev.gate;
  endproperty
  a_stop_empty: assert property (p_stop_empty) else $error("note with no keys");
  property p_up_order;
    (note_ev.trig && st_q.last_v && $past(st_q.last_v)) |->
      (note_ev.note > $past(st_q.last_note)) || (st_q.idx == 7'h00);
  endproperty
  a_up_order: assert property (p_up_order) else $error("up order broken");
  property p_chord;
    (note_ev.trig && note_ev.chord) |-> (note_ev.mask != '0) && (pat == ARP_TRIG);
  endproperty
  a_chord: assert property (p_chord) else $error("empty chord");
  property p_gate_zero;
    (note_ev.trig && st_q.tmp[`ARP_F_GATE] == 7'h00) |=> !note_ev.gate || note_ev.trig;
  endproperty
  a_gate_zero: assert property (p_gate_zero) else $error("zero gate held");
  property p_gate_full;
    (note_ev.gate && playing && st_q.tmp[`ARP_F_GATE] == `ARP_GATE_MAX) |=> note_ev.gate;
  endproperty
  a_gate_full: assert property (p_gate_full) else $error("full gate dropped");
  property p_channel;
    (note_ev.trig && note_ev.to_t1) |-> $past(st_q.chan[`ARP_F_T1CH] == st_q.chan[`ARP_F_GCH]);
  endproperty
  a_channel: assert property (p_channel) else $error("timbre off global channel");
  property p_ext_hold;
    (st_q.ctrl[`ARP_B_EXT] && !ext_tick && !st_q.restart) |=> !note_ev.trig;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("step without clock");
  property p_key_sync;
    s_sync_key |-> s_restart_out;
  endproperty
  a_key_sync: assert property (p_key_sync) else $error("key sync missed");
  property p_tempo_range;
    (seq_tempo >= `ARP_TEMPO_MIN) && (seq_tempo <= `ARP_TEMPO_MAX);
  endproperty
  a_tempo_range: assert property (p_tempo_range) else $error("tempo out of range");
endmodule : arp_seq

// ==== arp_seq_consts.svh ====
// Register map, field positions, reset values and timing constants of the note sequencer.
`ifndef ARP_SEQ_CONSTS_SVH
`define ARP_SEQ_CONSTS_SVH
`define ARP_REG_CTRL    8'h00
`define ARP_REG_TEMPO   8'h04
`define ARP_REG_CHAN    8'h08
`define ARP_REG_STAT    8'h0C
`define ARP_CTRL_RST    32'h0000_0400
`define ARP_TEMPO_RST   32'h0050_0078
`define ARP_CHAN_RST    32'h0000_0000
`define ARP_F_PAT       2:0
`define ARP_F_RANGE     5:4
`define ARP_F_RES       10:8
`define ARP_B_EXT       12
`define ARP_B_KSYNC     13
`define ARP_F_TSEL      17:16
`define ARP_B_DUAL      18
`define ARP_F_TEMPO     8:0
`define ARP_F_GATE      22:16
`define ARP_F_SWING     31:24
`define ARP_F_GCH       3:0
`define ARP_F_T1CH      7:4
`define ARP_F_T2CH      11:8
`define ARP_TEMPO_MIN   9'h014
`define ARP_TEMPO_MAX   9'h12C
`define ARP_GATE_MAX    7'h64
`define ARP_SWING_MAX   8'sh64
`define ARP_CLK_HZ      36'h5F5_E100
`define ARP_BEAT_SEC    36'h3C
`define ARP_WHOLE_BEATS 36'h4
`define ARP_EXT_PPW     36'h60
`define ARP_PCT_DIV     36'h64
`define ARP_SWING_DIV   36'hC8
`define ARP_OCT_SEMIS   8'h0C
`define ARP_NOTE_TOP    8'h7F
`define ARP_RESP_OKAY   2'h0
`define ARP_RESP_SLVERR 2'h2
`define ARP_LFSR_SEED   16'hACE1
`define ARP_LFSR_TAPS   16'hB400
`endif

// ==== arp_pkg.sv ====
// Types shared by the note sequencer and its users.
package arp_pkg;
  typedef enum logic [2:0] {
    ARP_UP = 3'h0, ARP_DOWN = 3'h1, ARP_ALT1 = 3'h2,
    ARP_ALT2 = 3'h3, ARP_RAND = 3'h4, ARP_TRIG = 3'h5
  } arp_pat_t;
  typedef struct packed {
    logic       on;    // Key pressed this cycle.
    logic       off;   // Key released this cycle.
    logic [6:0] note;  // Key number.
  } arp_key_t;
  typedef struct packed {
    logic         trig;  // One-cycle trigger of a new note or chord.
    logic         gate;  // Level: note is sounding.
    logic         chord; // Trigger carries the whole chord in mask.
    logic         to_t1; // Drive timbre one.
    logic         to_t2; // Drive timbre two.
    logic [6:0]   note;  // Note number of a single trigger.
    logic [127:0] mask;  // Notes of a chord trigger.
  } arp_ev_t;
  typedef struct packed {
    logic         aw_v, w_v, bvalid, rvalid;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic [1:0]   bresp, rresp;
    logic [31:0]  rdata, ctrl, tmp, chan;
    logic         en, latch, restart, dn, last_v;
    logic [127:0] held, play;
    logic [35:0]  acc, gate_rem;
    logic [6:0]   idx, last_note;
    logic [1:0]   oct;
    logic [15:0]  lfsr;
    arp_ev_t      ev;
  } arp_st_t;
endpackage : arp_pkg

// ==== arp_kbd_model.sv ====
// Keyboard and tone-generator voices facing the note sequencer.
`timescale 1ns/10ps
module arp_kbd_model (
  input  wire logic             aclk,    // System clock.
  input  wire arp_pkg::arp_ev_t note_ev, // Note events from the sequencer.
  output arp_pkg::arp_key_t     key_ev   // Key presses and releases.
);
  import arp_pkg::*;
  arp_ev_t got [$]; // Every trigger the voices have heard.
  // Keys stay quiet until the bench plays one.
  initial key_ev = '0;
  // The voices log each trigger pulse in the cycle it stands.
  always @(posedge aclk)
  begin
    if (note_ev.trig === 1'b1) got.push_back(note_ev);
  end
  // One key press or release, then a quiet cycle so pulses never merge.
  task automatic key(input logic on, input logic [6:0] n);
    key_ev <= '{on: on, off: !on, note: n};
    @(posedge aclk);
    key_ev <= '0;
    @(posedge aclk);
  endtask : key
endmodule : arp_kbd_model

// ==== tb_top.sv ====
// Self-checking bench for the note sequencer.
`timescale 1ns/10ps
`include "arp_seq_consts.svh"
module tb_top;
  import arp_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arp_led;
  logic arvalid, arready, rvalid, rready, arp_key, latch_key, ext_tick, latch_led;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [8:0] seq_tempo;
  arp_key_t key_ev;
  arp_ev_t note_ev;
  int bad_count = 0, total_checks = 0, cyc = 0, ok;
  // Pattern table: control word, channels, expected notes, {timbre1, timbre2}.
  logic [31:0] row_ctrl [8] = '{32'h0000_1500, 32'h0000_1501, 32'h0000_1502,
    32'h0000_1503, 32'h0000_1510, 32'h0000_1531, 32'h0006_1500, 32'h0004_1500};
  logic [31:0] row_chan [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0000_0100};
  logic [1:0] row_tt [8] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h2};
  logic [6:0] row_note [8][7] = '{'{7'h3C, 7'h40, 7'h43, 7'h3C, 7'h40, 7'h43, 7'h3C},
    '{7'h43, 7'h40, 7'h3C, 7'h43, 7'h40, 7'h3C, 7'h43},
    '{7'h3C, 7'h40, 7'h43, 7'h40, 7'h3C, 7'h40, 7'h43},
    '{7'h3C, 7'h40, 7'h43, 7'h43, 7'h40, 7'h3C, 7'h3C},
    '{7'h3C, 7'h40, 7'h43, 7'h48, 7'h4C, 7'h4F, 7'h3C},
    '{7'h67, 7'h64, 7'h60, 7'h5B, 7'h58, 7'h54, 7'h4F},
    '{7'h3C, 7'h40, 7'h43, 7'h3C, 7'h40, 7'h43, 7'h3C},
    '{7'h3C, 7'h40, 7'h43, 7'h3C, 7'h40, 7'h43, 7'h3C}};
  // Three voices only, so the fourth held key must stay silent.
  arp_seq #(.MAX_VOICES(3)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .key_ev(key_ev), .arp_key(arp_key), .latch_key(latch_key), .ext_tick(ext_tick),
    .note_ev(note_ev), .arp_led(arp_led), .latch_led(latch_led), .seq_tempo(seq_tempo));
  arp_kbd_model u_kbd (.aclk(aclk), .note_ev(note_ev), .key_ev(key_ev));
  // Free-running 100 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Hang guard: a run past the ceiling is a mismatch.
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Write with address and data offered together; bready is always high.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awvalid && awready) begin ta = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin tw = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask : wr
  // Read; rready is always high, so the first rvalid edge takes the data.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
  endtask : rd
  // One panel key pulse: latch key when l is set, else enable key.
  task automatic tap(input logic l);
    if (l) latch_key <= 1'b1;
    else arp_key <= 1'b1;
    @(posedge aclk);
    latch_key <= 1'b0;
    arp_key <= 1'b0;
    @(posedge aclk);
  endtask : tap
  // External timing clock pulses, three system cycles apart.
  task automatic ticks(input int n);
    repeat (n) begin
      ext_tick <= 1'b1;
      @(posedge aclk);
      ext_tick <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask : ticks
  // Stop, reconfigure and restart so the pattern begins at its first step.
  task automatic play(input logic [31:0] c, input logic [31:0] ch);
    tap(1'b0);
    wr(`ARP_REG_CTRL, c);
    wr(`ARP_REG_CHAN, ch);
    u_kbd.got.delete();
    tap(1'b0);
    ticks(32);
  endtask : play
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial
  begin
    {awvalid, wvalid, arvalid, arp_key, latch_key, ext_tick, aresetn} = '0;
    {bready, rready, wstrb, awaddr, araddr, wdata} = {2'h3, 4'hF, 48'h0};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ARP_REG_CTRL, d); chk(d, `ARP_CTRL_RST);
    rd(`ARP_REG_TEMPO, d); chk(d, `ARP_TEMPO_RST);
    chk(seq_tempo, 9'h078);
    rd(8'h10, d); chk({resp, d}, {`ARP_RESP_SLVERR, 32'h0});
    wr(8'h10, 32'h0); chk(resp, `ARP_RESP_SLVERR);
    wr(`ARP_REG_TEMPO, 32'h0050_0005); rd(`ARP_REG_TEMPO, d);
    chk(d[`ARP_F_TEMPO], `ARP_TEMPO_MIN);
    wr(`ARP_REG_TEMPO, 32'h0050_01FF); rd(`ARP_REG_TEMPO, d);
    chk(d[`ARP_F_TEMPO], `ARP_TEMPO_MAX);
    chk(seq_tempo, `ARP_TEMPO_MAX);
    wr(`ARP_REG_TEMPO, `ARP_TEMPO_RST);
    $display("register test done");
    u_kbd.key(1'b1, 7'h3C); u_kbd.key(1'b1, 7'h40); u_kbd.key(1'b1, 7'h43); u_kbd.key(1'b1, 7'h46);
    tap(1'b0); chk(arp_led, 1'b1);
    wr(`ARP_REG_STAT, 32'h0); rd(`ARP_REG_STAT, d); chk(d[0], 1'b1);
    $display("enable test done");
    for (int r = 0; r < 8; r++) begin
      play(row_ctrl[r], row_chan[r]);
      for (int i = 0; i < 7; i++) chk(u_kbd.got[i].note, row_note[r][i]);
      chk({u_kbd.got[0].to_t1, u_kbd.got[0].to_t2}, row_tt[r]);
    end
    $display("pattern test done");
    // Swing +100 and full gate: the even step lands late and the gate holds.
    wr(`ARP_REG_TEMPO, 32'h6464_0078); play(32'h0000_3500, 32'h0);
    u_kbd.got.delete();
    ticks(5); chk(u_kbd.got.size(), 0); chk(note_ev.gate, 1'b1);
    ticks(1); chk(u_kbd.got.size(), 1);
    // Zero gate and key sync: a held key restarts and the gate drops at once.
    wr(`ARP_REG_TEMPO, 32'h0000_0078); u_kbd.key(1'b1, 7'h46);
    @(posedge aclk); chk({note_ev.trig, note_ev.note}, {1'b1, 7'h3C});
    @(posedge aclk); chk(note_ev.gate, 1'b0);
    $display("swing, gate and sync test done");
    play(32'h0000_1504, 32'h0);
    for (int i = 0; i < 7; i++) begin
      ok = u_kbd.got[i].note inside {7'h3C, 7'h40, 7'h43};
      chk(ok, 1);
    end
    play(32'h0000_1515, 32'h0);
    chk(u_kbd.got[1].chord, 1'b1);
    chk(u_kbd.got[1].mask, 128'h0000_0000_0000_0009_1000_0000_0000_0000);
    $display("random and chord test done");
    u_kbd.key(1'b0, 7'h3C); u_kbd.key(1'b0, 7'h40); u_kbd.key(1'b0, 7'h43); u_kbd.key(1'b0, 7'h46);
    u_kbd.got.delete();
    ticks(16); chk(u_kbd.got.size(), 0);
    tap(1'b1); chk(latch_led, 1'b1);
    u_kbd.key(1'b1, 7'h3C); u_kbd.key(1'b0, 7'h3C);
    u_kbd.got.delete();
    ticks(16); chk(u_kbd.got[1].mask[60], 1'b1);
    $display("latch test done");
    close_out();
  end
endmodule : tb_top
